// ---- core/ctv_pkg.sv ----
/*
  Constants for the calendar time and match value window block: access
  selects, pointer codes, slot indices and the implemented-bit masks of
  each packed BCD value register.
  Assumes a single 8-bit processor register port on one system clock.
*/
package ctv_pkg;

  // data and pointer widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W  = 2;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned SLOTS  = 8;

  // access selects on the processor register port
  localparam logic [2:0] SEL_TIME_HIGH  = 3'h0;
  localparam logic [2:0] SEL_TIME_LOW   = 3'h1;
  localparam logic [2:0] SEL_MATCH_HIGH = 3'h2;
  localparam logic [2:0] SEL_MATCH_LOW  = 3'h3;
  localparam logic [2:0] SEL_TIME_PTR   = 3'h4;
  localparam logic [2:0] SEL_MATCH_PTR  = 3'h5;

  // pointer codes
  localparam logic [1:0] PTR_00    = 2'h0;
  localparam logic [1:0] PTR_01    = 2'h1;
  localparam logic [1:0] PTR_10    = 2'h2;
  localparam logic [1:0] PTR_11    = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;

  // slot index = {low window, pointer}
  localparam logic [2:0] SLOT_MINUTE  = 3'h0;
  localparam logic [2:0] SLOT_WEEKDAY = 3'h1;
  localparam logic [2:0] SLOT_MONTH   = 3'h2;
  localparam logic [2:0] SLOT_UNUSED  = 3'h3;
  localparam logic [2:0] SLOT_SECOND  = 3'h4;
  localparam logic [2:0] SLOT_HOUR    = 3'h5;
  localparam logic [2:0] SLOT_DAY     = 3'h6;
  localparam logic [2:0] SLOT_YEAR    = 3'h7;

  // implemented bits of each value register
  localparam logic [7:0] MASK_YEAR    = 8'hFF;  // tens 7:4, ones 3:0
  localparam logic [7:0] MASK_MONTH   = 8'h1F;  // tens 4, ones 3:0
  localparam logic [7:0] MASK_DAY     = 8'h3F;  // tens 5:4, ones 3:0
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;  // digit 2:0
  localparam logic [7:0] MASK_HOUR    = 8'h3F;  // tens 5:4, ones 3:0
  localparam logic [7:0] MASK_MINUTE  = 8'h7F;  // tens 6:4, ones 3:0
  localparam logic [7:0] MASK_SECOND  = 8'h7F;  // tens 6:4, ones 3:0
  localparam logic [7:0] MASK_NONE    = 8'h00;

  localparam logic [7:0] RDATA_RESET  = 8'h00;

endpackage : ctv_pkg

// ---- core/ctv_value_window.sv ----
/*
  Calendar time and match value registers behind two pointer-selected
  windows each (high and low), with the two window pointers.
  Assumes the write-unlock bit and its unlock sequence live in the
  configuration logic beside this block, on the same system clock.
*/
// Summary of operation
// - year holds tens digit bits 7:4 and ones digit bits 3:0.
// - year writes land only while write-unlock is one.
// - month holds one tens bit at bit 4, ones digit bits 3:0.
// - day of month holds tens bits 5:4, ones digit bits 3:0.
// - weekday holds one digit in bits 2:0, zero to six.
// - hour holds tens bits 5:4, ones digit bits 3:0.
// - minute holds tens bits 6:4, ones digit bits 3:0.
// - second holds tens bits 6:4, ones digit bits 3:0.
// - month, day, weekday, hour writes need write-unlock set.
// - reserved time slot reads all zero.
// - unimplemented upper bits read as zero.
// - digit bits are undefined after reset until written.
// - match month mirrors month layout, writes need write-unlock.
// - match day mirrors day layout, writes need write-unlock.
// - match weekday mirrors weekday layout, writes need write-unlock.
// - match hour mirrors hour layout, writes need write-unlock.
// - time pointer selects pair; high-window access decrements it to zero.
// - match pointer selects pair; high-window access decrements it to zero.
// - software sets write-unlock by sequence; clear bit locks value writes.
`timescale 1ns/1ps
`default_nettype none

module ctv_value_window (
  input  wire logic       clk,               // system clock, 250 MHz
  input  wire logic       arst_n,            // asynchronous reset, active low
  input  wire logic [2:0] accessSel,         // window or pointer select
  input  wire logic       writeStrobe,       // one-cycle write request
  input  wire logic       readStrobe,        // one-cycle read request
  input  wire logic [7:0] writeData,         // write data
  input  wire logic       valueWriteUnlock,  // write-unlock level
  output logic      [7:0] readData,          // read data, valid after read
  output logic      [1:0] timeWindowPointer, // time window pointer
  output logic      [1:0] matchWindowPointer // match window pointer
);

  ////////////////////////////////////////////////////////////////////////
  // slot masks

  // zero mask marks a slot with no storage
  function automatic logic [7:0] slotMask(input logic isMatch, input logic [2:0] slot);
    logic [7:0] m;
    m = ctv_pkg::MASK_NONE;
    case (slot)
      ctv_pkg::SLOT_MINUTE:  m = isMatch ? ctv_pkg::MASK_NONE : ctv_pkg::MASK_MINUTE;
      ctv_pkg::SLOT_WEEKDAY: m = ctv_pkg::MASK_WEEKDAY;
      ctv_pkg::SLOT_MONTH:   m = ctv_pkg::MASK_MONTH;
      ctv_pkg::SLOT_SECOND:  m = isMatch ? ctv_pkg::MASK_NONE : ctv_pkg::MASK_SECOND;
      ctv_pkg::SLOT_HOUR:    m = ctv_pkg::MASK_HOUR;
      ctv_pkg::SLOT_DAY:     m = ctv_pkg::MASK_DAY;
      ctv_pkg::SLOT_YEAR:    m = isMatch ? ctv_pkg::MASK_NONE : ctv_pkg::MASK_YEAR;
      default:               m = ctv_pkg::MASK_NONE;
    endcase
    return m;
  endfunction : slotMask

  function automatic logic [1:0] ptrDown(input logic [1:0] p);
    return (p == ctv_pkg::PTR_00) ? ctv_pkg::PTR_00 : p - 2'h1;
  endfunction : ptrDown

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic [7:0] timeMem  [ctv_pkg::SLOTS];
  logic [7:0] matchMem [ctv_pkg::SLOTS];
  logic [1:0] timePtr_r;
  logic [1:0] matchPtr_r;
  logic [7:0] readData_r;

  wire        selTimeHigh  = (accessSel == ctv_pkg::SEL_TIME_HIGH);
  wire        selTimeLow   = (accessSel == ctv_pkg::SEL_TIME_LOW);
  wire        selMatchHigh = (accessSel == ctv_pkg::SEL_MATCH_HIGH);
  wire        selMatchLow  = (accessSel == ctv_pkg::SEL_MATCH_LOW);
  wire        selTimeWin   = selTimeHigh | selTimeLow;
  wire        selMatchWin  = selMatchHigh | selMatchLow;
  wire        accessAny    = writeStrobe | readStrobe;
  wire [2:0]  timeSlot     = {selTimeLow, timePtr_r};
  wire [2:0]  matchSlot    = {selMatchLow, matchPtr_r};
  wire [7:0]  timeMask     = slotMask(1'b0, timeSlot);
  wire [7:0]  matchMask    = slotMask(1'b1, matchSlot);

  wire        timeWrite    = writeStrobe & selTimeWin & valueWriteUnlock;
  wire        matchWrite   = writeStrobe & selMatchWin & valueWriteUnlock;

  wire [7:0]  readMux      = selTimeWin  ? (timeMem[timeSlot] & timeMask)  :
                             selMatchWin ? (matchMem[matchSlot] & matchMask) :
                             (accessSel == ctv_pkg::SEL_TIME_PTR)  ? {6'h00, timePtr_r} :
                             (accessSel == ctv_pkg::SEL_MATCH_PTR) ? {6'h00, matchPtr_r} :
                             ctv_pkg::RDATA_RESET;

  wire [1:0]  timePtr_nxt  = (writeStrobe && accessSel == ctv_pkg::SEL_TIME_PTR) ?
                             writeData[1:0] :
                             (accessAny && selTimeHigh) ? ptrDown(timePtr_r) : timePtr_r;
  wire [1:0]  matchPtr_nxt = (writeStrobe && accessSel == ctv_pkg::SEL_MATCH_PTR) ?
                             writeData[1:0] :
                             (accessAny && selMatchHigh) ? ptrDown(matchPtr_r) : matchPtr_r;

  ////////////////////////////////////////////////////////////////////////
  // storage

  always_ff @(posedge clk) begin
    if (timeWrite) begin
      timeMem[timeSlot] <= writeData & timeMask;
    end
    if (matchWrite) begin
      matchMem[matchSlot] <= writeData & matchMask;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timePtr_r  <= ctv_pkg::PTR_RESET;
      matchPtr_r <= ctv_pkg::PTR_RESET;
      readData_r <= ctv_pkg::RDATA_RESET;
    end else begin
      timePtr_r  <= timePtr_nxt;
      matchPtr_r <= matchPtr_nxt;
      if (readStrobe) begin
        readData_r <= readMux;
      end
    end
  end

  assign readData           = readData_r;
  assign timeWindowPointer  = timePtr_r;
  assign matchWindowPointer = matchPtr_r;

endmodule : ctv_value_window

`default_nettype wire

// ---- testbench/ctv_tb.sv ----
/* Bench for the value window block: table-driven window sweeps.
   Assumes the package and design are compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin errCount++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic       clk;
  logic       arst_n;
  logic [2:0] sel;
  logic       wrS, rdS, unlock;
  logic [7:0] wData, rData;
  logic [1:0] tPtr, mPtr;
  int         errCount, testsRun, cyc;
  // masks per {window, pointer}: time high, time low, match high, match low
  logic [7:0] msk [16] = '{8'h7F, 8'h07, 8'h1F, 8'h00, 8'h7F, 8'h3F, 8'h3F, 8'hFF,
                           8'h00, 8'h07, 8'h1F, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h00};
  ctv_value_window u_dut (.clk(clk), .arst_n(arst_n), .accessSel(sel), .writeStrobe(wrS),
    .readStrobe(rdS), .writeData(wData), .valueWriteUnlock(unlock), .readData(rData),
    .timeWindowPointer(tPtr), .matchWindowPointer(mPtr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic acc(input logic [2:0] s, input logic wr, input logic [7:0] d);
    @(negedge clk);
    sel <= s;
    wrS <= wr;
    rdS <= !wr;
    wData <= d;
    @(negedge clk);
    wrS <= 1'b0;
    rdS <= 1'b0;
  endtask : acc
  // every slot: load pointer, write d, reload, read back masked e
  task automatic sweep(input logic [7:0] d, input logic [7:0] e);
    logic [2:0] ps;
    for (int w = 0; w < 4; w++) begin
      for (int p = 0; p < 4; p++) begin
        ps = (w < 2) ? 3'h4 : 3'h5;
        acc(ps, 1'b1, 8'(p));
        acc(3'(w), 1'b1, d);
        acc(ps, 1'b1, 8'(p));
        acc(3'(w), 1'b0, 8'h00);
        `CHK("slot", msk[w * 4 + p] & e, rData)
        `CHK("pointer", 2'((w % 2 == 1 || p == 0) ? p : p - 1), w < 2 ? tPtr : mPtr)
      end
    end
  endtask : sweep
  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : completeRun
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    sel = 3'h0;
    wrS = 1'b0;
    rdS = 1'b0;
    wData = 8'h00;
    unlock = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    `CHK("reset state", 12'h000, {rData, tPtr, mPtr})
    $display("test reset done");
    sweep(8'hFF, 8'hFF);
    $display("test unlocked fill done");
    unlock = 1'b0;
    sweep(8'h00, 8'hFF);
    $display("test locked writes done");
    unlock = 1'b1;
    sweep(8'hA5, 8'hA5);
    $display("test pattern fill done");
    acc(3'h6, 1'b1, 8'hFF);
    acc(3'h1, 1'b0, 8'h00);
    acc(3'h7, 1'b0, 8'h00);
    `CHK("unmapped", 8'h00, rData)
    $display("test unmapped done");
    acc(3'h4, 1'b1, 8'h02);
    acc(3'h4, 1'b0, 8'h00);
    `CHK("time pointer read", 8'h02, rData)
    acc(3'h5, 1'b1, 8'h01);
    acc(3'h5, 1'b0, 8'h00);
    `CHK("match pointer read", 8'h01, rData)
    $display("test pointer readback done");
    // second reset: pointers and read data must drop back while the run goes on
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    `CHK("mid-run reset", 12'h000, {rData, tPtr, mPtr})
    $display("test mid-run reset done");
    completeRun();
  end
  // hang guard: the sweeps need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errCount++;
      completeRun();
    end
  end
endmodule : testbench
bind ctv_value_window ctv_value_window_checker u_chk (.clk(clk), .arst_n(arst_n),
  .accessSel(accessSel), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
  .writeData(writeData), .valueWriteUnlock(valueWriteUnlock), .readData(readData),
  .timeWindowPointer(timeWindowPointer), .matchWindowPointer(matchWindowPointer));
`default_nettype wire

// ---- testbench/ctv_value_window_assertions.sv ----
/* Checker for the value window block: pointer and read data relations.
   Sees only the block's ports; bound to it from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module ctv_value_window_checker (
  input wire logic       clk,               // system clock
  input wire logic       arst_n,            // async reset, active low
  input wire logic [2:0] accessSel,         // window or pointer select
  input wire logic       writeStrobe,       // write pulse
  input wire logic       readStrobe,        // read pulse
  input wire logic [7:0] writeData,         // write data
  input wire logic       valueWriteUnlock,  // unlock level
  input wire logic [7:0] readData,          // read data
  input wire logic [1:0] timeWindowPointer, // time pointer
  input wire logic [1:0] matchWindowPointer // match pointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire tHi = (writeStrobe || readStrobe) && accessSel == 3'h0;
  wire mHi = (writeStrobe || readStrobe) && accessSel == 3'h2;
  sequence tLoad; writeStrobe && accessSel == 3'h4; endsequence
  sequence mLoad; writeStrobe && accessSel == 3'h5; endsequence
  ////////////////////////////////////////////////////////////////
  rd_hold_a: assert property (!readStrobe |=> $stable(readData))
    else $error("read data moved without a read");
  tptr_load_a: assert property (tLoad |=>
    {6'h00, timeWindowPointer} == ($past(writeData) & 8'h03))
    else $error("time pointer load wrong");
  mptr_load_a: assert property (mLoad |=>
    {6'h00, matchWindowPointer} == ($past(writeData) & 8'h03))
    else $error("match pointer load wrong");
  tptr_dec_a: assert property (tHi |=>
    timeWindowPointer + {1'b0, $past(timeWindowPointer) != 2'h0} == $past(timeWindowPointer))
    else $error("time pointer step wrong");
  mptr_dec_a: assert property (mHi |=>
    matchWindowPointer + {1'b0, $past(matchWindowPointer) != 2'h0} == $past(matchWindowPointer))
    else $error("match pointer step wrong");
  tptr_hold_a: assert property (!tHi && !(writeStrobe && accessSel == 3'h4) |=>
    $stable(timeWindowPointer))
    else $error("time pointer moved");
  mptr_hold_a: assert property (!mHi && !(writeStrobe && accessSel == 3'h5) |=>
    $stable(matchWindowPointer))
    else $error("match pointer moved");
  tptr_read_a: assert property (readStrobe && accessSel == 3'h4 |=>
    readData == {6'h00, $past(timeWindowPointer)})
    else $error("time pointer read back wrong");
  mptr_read_a: assert property (readStrobe && accessSel == 3'h5 |=>
    readData == {6'h00, $past(matchWindowPointer)})
    else $error("match pointer read back wrong");
  rsvd_zero_a: assert property (readStrobe && accessSel == 3'h0 &&
    timeWindowPointer == 2'h3 |=> readData == 8'h00)
    else $error("reserved slot not zero");
  unmapped_zero_a: assert property (readStrobe && accessSel[2:1] == 2'b11 |=>
    readData == 8'h00)
    else $error("unmapped read not zero");
  match_low_top_a: assert property (readStrobe && accessSel == 3'h3 |=>
    readData[7:6] == 2'b00)
    else $error("match low upper bits set");
  time_high_top_a: assert property (readStrobe && accessSel == 3'h0 |=> !readData[7])
    else $error("time high bit 7 set");
endmodule : ctv_value_window_checker
`default_nettype wire
